// ===== presc_if.sv
/*
 * Link between the watchdog core and its prescaler.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/10ps
interface presc_if;
    logic run;
    logic clear;
    logic sel_long;
    logic tick;
    modport ctl (output run, output clear, output sel_long, input tick);
    modport pre (input run, input clear, input sel_long, output tick);
endinterface : presc_if

// ===== tb_top.sv
/*
 * Self-checking bench of the watchdog core with an APB master.
 * Assumes zero-wait APB and the CPU model as instruction source.
 */
`timescale 1ns/10ps
module tb_top;
    import wdt_pkg::*;
    localparam int PW = 4;
    logic core_clk, sys_rst, psel, penable, pwrite, pslverr, pready;
    logic irq, reset_request, srv, off, on;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int bad_count = 0;
    int n_compared = 0;
    int exp_reload, ticks, n;

    wdt_core #(.PREWARN_CYCLES(PW)) u_wdt_core (.core_clk(core_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .service_instruction(srv), .watchdog_off_instruction(off),
        .watchdog_on_instruction(on), .irq(irq),
        .reset_request(reset_request));
    wdt_cpu_model u_wdt_cpu_model (.core_clk(core_clk),
        .service_instruction(srv), .watchdog_off_instruction(off),
        .watchdog_on_instruction(on));

    // Clock of 100 ns period.
    always #50 core_clk = ~core_clk;

    // Prints the verdict and stops the run.
    task automatic end_sim;
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // Compares a design value with the model value.
    task automatic chk(input logic [31:0] got, input int exp);
        n_compared++;
        if (got !== 32'(exp)) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the access phase is held until pready.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(0, 1);
            end_sim();
        end
        rdat = prdata;
        chk({31'b0, pslverr}, int'(a > ADDR_MASK));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads a register and compares the masked value.
    task automatic rd(input logic [7:0] a, input int m, input int exp);
        apb(1'b0, a, 32'h0);
        chk(rdat & 32'(m), exp);
    endtask : rd

    // Waits a bounded number of cycles for irq or reset_request.
    task automatic wait_hi(input logic which, input int lim);
        n = 0;
        while ((which ? reset_request : irq) !== 1'b1 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= lim) begin
            chk(0, 1);
            end_sim();
        end
    endtask : wait_hi

    // Main sequence of scenarios.
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(32'h62983186));
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        exp_reload = 'hff02;
        rd(ADDR_RELOAD, 'hffff, exp_reload);
        rd(ADDR_CTRL, 'h1, 0);
        rd(ADDR_MASK, 'h1, 1);
        rd(ADDR_STATUS, 'hd, 'h4);
        rd(8'h20, -1, 0);
        exp_reload = 'hfffc + ($urandom % 3);
        apb(1'b1, ADDR_RELOAD, 32'(exp_reload));
        u_wdt_cpu_model.strobe(0);
        rd(ADDR_COUNT, 'hffff, exp_reload);
        repeat (256) @(posedge core_clk);
        rd(ADDR_COUNT, 'hffff, exp_reload + 1);
        u_wdt_cpu_model.strobe(1);
        rd(ADDR_STATUS, 'h4, 0);
        repeat (600) @(posedge core_clk);
        rd(ADDR_COUNT, 'hffff, exp_reload + 1);
        u_wdt_cpu_model.strobe(2);
        rd(ADDR_STATUS, 'h4, 'h4);
        apb(1'b1, ADDR_CTRL, 32'h1);
        u_wdt_cpu_model.strobe(0);
        repeat (1000) @(posedge core_clk);
        rd(ADDR_COUNT, 'hffff, exp_reload);
        // The long ratio gives its first tick after 16,384 clocks.
        repeat (15400) @(posedge core_clk);
        rd(ADDR_COUNT, 'hffff, exp_reload + 1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        u_wdt_cpu_model.strobe(0);
        ticks = 'h10000 - exp_reload;
        // Clear the prewarning flag in the very cycle that sets it.
        repeat (256 * ticks - 3) @(posedge core_clk);
        chk({31'b0, irq}, 0);
        apb(1'b1, ADDR_STATUS, 32'h1);
        wait_hi(1'b0, 4);
        chk(32'(n <= 1), 1);
        chk({31'b0, reset_request}, 0);
        wait_hi(1'b1, 50);
        chk(32'(n >= PW - 1 && n <= PW + 1), 1);
        rd(ADDR_STATUS, 'h9, 'h9);
        apb(1'b1, ADDR_MASK, 32'h0);
        @(negedge core_clk);
        chk({31'b0, irq}, 0);
        apb(1'b1, ADDR_MASK, 32'h1);
        @(negedge core_clk);
        chk({31'b0, irq}, 1);
        apb(1'b1, ADDR_STATUS, 32'h1);
        rd(ADDR_STATUS, 'h1, 0);
        chk({31'b0, irq}, 0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk({31'b0, reset_request}, 0);
        rd(ADDR_STATUS, 'h4, 'h4);
        end_sim();
    end
endmodule : tb_top

// ===== wdt_core.sv
/*
 * Fail-safe watchdog: 16-bit up counter on a prescaled tick, reload
 * register, service and on/off instructions, prewarning interrupt and
 * a reset request, with an APB register port.
 * Assumes the CPU core gives one-cycle instruction strobes on
 * core_clk and the reset controller asserts sys_rst on the request.
 */
// Functional notes
// - After reset the watchdog runs without any software action.
// - Off instruction stops the watchdog, on instruction restarts it.
// - Overflow raises prewarning interrupt first, reset request after.
// - 16-bit counter ticks at clock divided by 16,384 or 256.
// - Counter starts from the software-programmed reload value.
// - Service reloads the counter and clears the prescaler together.
// - Ratio and reload cover about 3.2 us to 13.4 s at 80 MHz.
// - Reset defaults give a 6.5 ms interval at 10 MHz.
`timescale 1ns/10ps
module wdt_core
    import wdt_pkg::*;
#(
    parameter int PREWARN_CYCLES = 16
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic service_instruction,
    input wire logic watchdog_off_instruction,
    input wire logic watchdog_on_instruction,
    output logic irq,
    output logic reset_request
);
    localparam int DLY_W = $clog2(PREWARN_CYCLES + 1);
    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(PREWARN_CYCLES - 1);
    // Cycles from the second warning cycle to the reset request.
    localparam int WARN_DLY = PREWARN_CYCLES - 1;

    // Address match of one register word.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = a == o;
    endfunction : hit

    presc_if pif ();

    wd_state_t state_q;
    wd_state_t state_d;
    logic sel_long_q;
    logic [CNT_W-1:0] watchdog_reload_value_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [EV_W-1:0] status_q;
    logic [EV_W-1:0] status_d;
    logic [EV_W-1:0] mask_q;
    logic [DLY_W-1:0] dly_q;
    logic [DLY_W-1:0] dly_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Bus decode: zero wait states, unmapped words answer with an error.
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_ctrl = hit(paddr, ADDR_CTRL);
    wire hit_reload = hit(paddr, ADDR_RELOAD);
    wire hit_count = hit(paddr, ADDR_COUNT);
    wire hit_status = hit(paddr, ADDR_STATUS);
    wire hit_mask = hit(paddr, ADDR_MASK);
    wire mapped = hit_ctrl || hit_reload || hit_count || hit_status
                  || hit_mask;
    wire wr = access && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = rdata_q;

    // Read data are captured in the setup cycle and held through access.
    wire [31:0] status_word = {28'h0000000,
                               state_q == WD_RESET,
                               state_q != WD_OFF,
                               1'b0,
                               status_q};
    assign rdata_d = !setup ? rdata_q :
                     hit_ctrl ? {31'h00000000, sel_long_q} :
                     hit_reload ? {16'h0000, watchdog_reload_value_q} :
                     hit_count ? {16'h0000, cnt_q} :
                     hit_status ? status_word :
                     hit_mask ? {31'h00000000, mask_q} : 32'h00000000;

    // Events of the watchdog core.
    wire running = state_q == WD_RUN;
    wire overflow = running && pif.tick && cnt_q == CNT_TOP;
    wire service = service_instruction && state_q != WD_RESET;
    wire warn_done = state_q == WD_WARN && dly_q == DLY_LAST;

    // Prescaler runs only while counting and restarts on service.
    assign pif.run = running;
    assign pif.clear = service;
    assign pif.sel_long = sel_long_q;

    // Sticky prewarning flag; a set in the clearing cycle wins.
    assign status_d = (status_q & ~(hit_status && wr ?
                                    pwdata[EV_W-1:0] : '0))
                      | {overflow};

    // Counter: service reloads, ticks count up, overflow reloads.
    assign cnt_d = service ? watchdog_reload_value_q :
                   overflow ? watchdog_reload_value_q :
                   running && pif.tick ? cnt_q + 1'b1 : cnt_q;

    // Delay counter between prewarning and reset request.
    assign dly_d = state_q == WD_WARN ? dly_q + 1'b1 : '0;

    // Sequencer of the watchdog.
    always_comb begin
        state_d = state_q;
        case (state_q)
            WD_OFF: begin
                if (watchdog_on_instruction && !watchdog_off_instruction) begin
                    state_d = WD_RUN;
                end
            end
            WD_RUN: begin
                if (overflow) begin
                    state_d = WD_WARN;
                end else if (watchdog_off_instruction) begin
                    state_d = WD_OFF;
                end
            end
            WD_WARN: begin
                if (warn_done) begin
                    state_d = WD_RESET;
                end
            end
            WD_RESET: begin
                state_d = WD_RESET;
            end
            default: begin
                state_d = WD_RESET;
            end
        endcase
    end

    // Interrupt and reset request outputs.
    assign irq = |(status_q & mask_q);
    assign reset_request = state_q == WD_RESET;

    // State, counter and delay registers.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= WD_RUN;
            cnt_q <= RELOAD_DEFAULT;
            dly_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            dly_q <= dly_d;
        end
    end

    // Software registers with their reset defaults.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_long_q <= CTRL_SEL_RESET;
            watchdog_reload_value_q <= RELOAD_DEFAULT;
            mask_q <= MASK_RESET;
            status_q <= '0;
            rdata_q <= '0;
        end else begin
            if (wr && hit_ctrl) begin
                sel_long_q <= pwdata[CTRL_SEL_LONG];
            end
            if (wr && hit_reload) begin
                watchdog_reload_value_q <= pwdata[CNT_W-1:0];
            end
            if (wr && hit_mask) begin
                mask_q <= pwdata[EV_W-1:0];
            end
            status_q <= status_d;
            rdata_q <= rdata_d;
        end
    end

    wdt_prescaler u_presc (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pif(pif.pre)
    );

    // After reset the watchdog runs with default settings.
    a_reset_runs: assert property (@(posedge core_clk)
        sys_rst |=> state_q == WD_RUN && cnt_q == RELOAD_DEFAULT)
        else $error("watchdog not running after reset");

    a_default_interval: assert property (@(posedge core_clk)
        sys_rst |=> !sel_long_q
                    && watchdog_reload_value_q == RELOAD_DEFAULT)
        else $error("wrong default interval settings");

    a_off_stops: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == WD_RUN && watchdog_off_instruction && !overflow
        |=> state_q == WD_OFF ##1 (state_q == WD_OFF
            || $past(watchdog_on_instruction)))
        else $error("off instruction did not stop the watchdog");

    a_on_starts: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == WD_OFF && watchdog_on_instruction
        && !watchdog_off_instruction |=> state_q == WD_RUN)
        else $error("on instruction did not start the watchdog");

    a_off_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == WD_OFF && !service |=> $stable(cnt_q))
        else $error("counter moved while stopped");

    a_tick_counts: assert property (@(posedge core_clk) disable iff (sys_rst)
        running && pif.tick && cnt_q != CNT_TOP && !service
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not advance on tick");

    a_no_tick_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        !pif.tick && !service |=> $stable(cnt_q))
        else $error("counter moved without a tick");

    a_service_reload: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        service |=> cnt_q == $past(watchdog_reload_value_q)
                    && !pif.tick)
        else $error("service did not reload the counter");

    a_warn_first: assert property (@(posedge core_clk) disable iff (sys_rst)
        overflow |=> status_q[ST_PREWARN] && !reset_request
                     && state_q == WD_WARN)
        else $error("prewarning missing after overflow");

    a_reset_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(state_q == WD_WARN) |-> !reset_request [*2]
        ##WARN_DLY reset_request)
        else $error("reset request not after the set delay");

    a_flag_set_wins: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        overflow && wr && hit_status |=> status_q[ST_PREWARN])
        else $error("prewarning lost under a clear");
endmodule : wdt_core

// ===== wdt_cpu_model.sv
/*
 * Model of the CPU core that issues the watchdog instructions.
 * Assumes the bench calls strobe from its own sequence on core_clk.
 */
`timescale 1ns/10ps
module wdt_cpu_model (
    input wire logic core_clk,
    output logic service_instruction,
    output logic watchdog_off_instruction,
    output logic watchdog_on_instruction
);
    // Strobes idle low until the core executes an instruction.
    initial begin
        service_instruction = 1'b0;
        watchdog_off_instruction = 1'b0;
        watchdog_on_instruction = 1'b0;
    end

    // One-cycle strobe: kind 0 services, 1 stops and 2 starts the timer.
    task automatic strobe(input int kind);
        @(posedge core_clk);
        service_instruction <= (kind == 0);
        watchdog_off_instruction <= (kind == 1);
        watchdog_on_instruction <= (kind == 2);
        @(posedge core_clk);
        service_instruction <= 1'b0;
        watchdog_off_instruction <= 1'b0;
        watchdog_on_instruction <= 1'b0;
    endtask : strobe
endmodule : wdt_cpu_model

// ===== wdt_pkg.sv
/*
 * Shared constants of the watchdog: register map, field positions,
 * reset values, prescaler ratios and the state encoding.
 * Assumes a 10 MHz core clock and a 32-bit APB register port.
 */
package wdt_pkg;
    // Core clock and the default monitored interval.
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEFAULT_INTERVAL_NS = 6500000;
    // Prescaler ratios and widths.
    localparam int PRESC_W = 14;
    localparam logic [PRESC_W-1:0] DIV_SHORT_LAST = 14'h00ff;
    localparam logic [PRESC_W-1:0] DIV_LONG_LAST = 14'h3fff;
    localparam int DIV_SHORT = 256;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;
    // Ticks of the default interval, rounded up, and its reload value.
    localparam int DEFAULT_TICKS =
        (DEFAULT_INTERVAL_NS / CLK_PERIOD_NS + DIV_SHORT - 1) / DIV_SHORT;
    localparam logic [CNT_W-1:0] RELOAD_DEFAULT =
        CNT_W'(17'h10000 - 17'(DEFAULT_TICKS));
    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RELOAD = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    // Field positions.
    localparam int CTRL_SEL_LONG = 0;
    localparam int ST_PREWARN = 0;
    localparam int ST_RUNNING = 2;
    localparam int ST_RESETREQ = 3;
    localparam int EV_W = 1;
    localparam logic CTRL_SEL_RESET = 1'b0;
    localparam logic [EV_W-1:0] MASK_RESET = 1'h1;
    // Watchdog states, one-hot.
    typedef enum logic [3:0] {
        WD_OFF = 4'h1,
        WD_RUN = 4'h2,
        WD_WARN = 4'h4,
        WD_RESET = 4'h8
    } wd_state_t;
endpackage : wdt_pkg

// ===== wdt_prescaler.sv
/*
 * Prescaler of the watchdog: one-cycle tick every 256 or 16,384
 * core clocks while running; cleared on request.
 * Assumes the controller drives the interface from the same clock.
 */
`timescale 1ns/10ps
module wdt_prescaler
    import wdt_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    presc_if.pre pif
);
    logic [PRESC_W-1:0] div_q;
    logic [PRESC_W-1:0] div_d;
    wire [PRESC_W-1:0] div_last;
    wire at_last;

    // Ratio select and the tick on the last count.
    assign div_last = pif.sel_long ? DIV_LONG_LAST : DIV_SHORT_LAST;
    assign at_last = div_q == div_last;
    assign pif.tick = pif.run && !pif.clear && at_last;

    // Clear wins, a stopped prescaler holds, a tick wraps to zero.
    assign div_d = pif.clear ? '0 :
                   !pif.run ? div_q :
                   at_last ? '0 : div_q + 1'b1;

    // Prescaler register.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // A clear leaves the prescaler at zero.
    a_clear_zeroes: assert property (@(posedge core_clk) disable iff (sys_rst)
        pif.clear |=> div_q == '0)
        else $error("prescaler not cleared");
endmodule : wdt_prescaler
